// *** src/prs_switch.sv ***
// reference clock switchover selector: loss sense, swap qualifier, glitch-free select
// assumes the reference pins are slower than half of SYS_CLK and the swap
// request comes from logic on SYS_CLK
//
// How it works
// - three modes: auto, manual, auto with override
// - auto mode leaves selected input once it stalls
// - manual swap needs rise held three input cycles
// - override: high request blocks further auto switching
// - two lost flags plus selected-input indicator
// - both inputs idle: no switchover starts
// - system keeps both inputs running within 2x
// - lost after two stuck periods, then move
// - over 20% difference only indicator valid
// - indicator always shows input feeding loop
// - gate on old fall, switch on new fall
// - override indicator follows request, flags stay low; the lost flags here still set when an input stalls
// - only request rising edge switches
// - wait for target input before completing switch
// - primary input selected out of reset
// - user drops request before next switchover
// - user holds request three slow periods
// - user requests only while both inputs run
// - user resets loop after a switchover
// - auto switching repeats any number of times
`default_nettype none
`include "prs_regs.svh"

module prs_switch (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic PRIMARY_REF_IN,
  input wire logic BACKUP_REF_IN,
  input wire prs_pkg::prs_mode_t MODE,
  output logic REF_OUT,
  output logic REF_GATE_EN,
  output logic REF_SEL,
  prs_if.dev link
);

  function automatic logic auto_on(input prs_pkg::prs_mode_t m);
    auto_on = (m == prs_pkg::PRS_MODE_AUTO) || (m == prs_pkg::PRS_MODE_OVERRIDE);
  endfunction : auto_on

  function automatic logic manual_on(input prs_pkg::prs_mode_t m);
    manual_on = (m == prs_pkg::PRS_MODE_MANUAL) || (m == prs_pkg::PRS_MODE_OVERRIDE);
  endfunction : manual_on

  logic [1:0] ref_pin;
  logic [1:0] ref_s1_r;
  logic [1:0] ref_s2_r;
  logic [1:0] ref_s3_r;
  logic [1:0] ref_rise;
  logic [1:0] ref_fall;
  logic [1:0] lost_r;
  logic [4:0] stuck_cnt_r [2];

  assign ref_pin = {BACKUP_REF_IN, PRIMARY_REF_IN};

  // per input: two-flop synchroniser, edge detect and stuck counter
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sense
      logic [4:0] stuck_nxt;
      logic lost_nxt;
      always_comb begin
        ref_rise[gi] = ref_s2_r[gi] & ~ref_s3_r[gi];
        ref_fall[gi] = ref_s3_r[gi] & ~ref_s2_r[gi];
        stuck_nxt = stuck_cnt_r[gi];
        if (ref_s2_r[gi] != ref_s3_r[gi]) begin
          stuck_nxt = 5'h00;
        end else if (stuck_cnt_r[gi] != 5'(`PRS_STUCK_CYC)) begin
          stuck_nxt = stuck_cnt_r[gi] + 5'h01;
        end
        lost_nxt = (stuck_nxt == 5'(`PRS_STUCK_CYC));
      end
      always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
          ref_s1_r[gi] <= 1'h0;
          ref_s2_r[gi] <= 1'h0;
          ref_s3_r[gi] <= 1'h0;
          stuck_cnt_r[gi] <= 5'h00;
          lost_r[gi] <= 1'h0;
        end else begin
          ref_s1_r[gi] <= ref_pin[gi];
          ref_s2_r[gi] <= ref_s1_r[gi];
          ref_s3_r[gi] <= ref_s2_r[gi];
          stuck_cnt_r[gi] <= stuck_nxt;
          lost_r[gi] <= lost_nxt;
        end
      end
    end
  endgenerate

  // swap request qualifier
  logic req_prev_r;
  logic armed_r;
  logic [1:0] hi_cnt_r;
  logic req_prev_nxt;
  logic armed_nxt;
  logic [1:0] hi_cnt_nxt;
  logic swap_fire;
  logic sel_r;

  always_comb begin
    req_prev_nxt = link.swap_req;
    armed_nxt = armed_r;
    hi_cnt_nxt = hi_cnt_r;
    swap_fire = 1'h0;
    if (!link.swap_req) begin
      armed_nxt = 1'h0;
      hi_cnt_nxt = 2'h0;
    end else begin
      if (!req_prev_r) begin
        armed_nxt = 1'h1;
        hi_cnt_nxt = 2'h0;
      end else if (armed_r && ref_rise[sel_r]) begin
        // high time counted in edges of the selected input
        if (hi_cnt_r == 2'(`PRS_SWAP_MIN_EDGES - 1)) begin
          swap_fire = 1'h1;
          armed_nxt = 1'h0;
        end else begin
          hi_cnt_nxt = hi_cnt_r + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      req_prev_r <= 1'h0;
      armed_r <= 1'h0;
      hi_cnt_r <= 2'h0;
    end else begin
      req_prev_r <= req_prev_nxt;
      armed_r <= armed_nxt;
      hi_cnt_r <= hi_cnt_nxt;
    end
  end

  // switchover state machine
  prs_pkg::prs_state_t state_r;
  prs_pkg::prs_state_t state_nxt;
  logic sel_nxt;
  logic gate_r;
  logic gate_nxt;
  logic ref_out_r;
  logic ref_out_nxt;
  logic auto_go;
  logic man_go;

  always_comb begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    gate_nxt = gate_r;
    // auto move only when the other input still runs
    auto_go = auto_on(MODE) && lost_r[sel_r] && !lost_r[~sel_r];
    if (MODE == prs_pkg::PRS_MODE_OVERRIDE && link.swap_req) begin
      auto_go = 1'h0;
    end
    man_go = manual_on(MODE) && swap_fire;
    case (state_r)
      prs_pkg::PRS_ST_RUN: begin
        if (man_go || auto_go) begin
          state_nxt = prs_pkg::PRS_ST_GATE;
        end
      end
      prs_pkg::PRS_ST_GATE: begin
        // a dead old input gives no falling edge, so gate at once
        if (ref_fall[sel_r] || lost_r[sel_r]) begin
          gate_nxt = 1'h0;
          state_nxt = prs_pkg::PRS_ST_SWAP;
        end
      end
      prs_pkg::PRS_ST_SWAP: begin
        // completes only once the new input is toggling
        if (ref_fall[~sel_r]) begin
          sel_nxt = ~sel_r;
          gate_nxt = 1'h1;
          state_nxt = prs_pkg::PRS_ST_RUN;
        end
      end
      default: begin
        state_nxt = prs_pkg::PRS_ST_RUN;
        gate_nxt = 1'h1;
      end
    endcase
    ref_out_nxt = gate_nxt & ref_s2_r[sel_nxt];
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_r <= prs_pkg::PRS_ST_RUN;
      sel_r <= `PRS_SEL_PRIMARY;
      gate_r <= 1'h1;
      ref_out_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      gate_r <= gate_nxt;
      ref_out_r <= ref_out_nxt;
    end
  end

  assign REF_OUT = ref_out_r;
  assign REF_GATE_EN = gate_r;
  assign REF_SEL = sel_r;
  assign link.active_sel = sel_r;
  assign link.lost_primary = lost_r[0];
  assign link.lost_backup = lost_r[1];

endmodule : prs_switch

`default_nettype wire

// *** src/prs_regs.svh ***
// timing counts and codes for the reference clock switchover pair
// assumes a single 25 MHz system clock that samples both reference pins
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH

`define PRS_SYS_CLK_NS 40
// stuck time before an input is flagged lost, about two reference periods
`define PRS_STUCK_TIME_NS 400
`define PRS_STUCK_CYC ((`PRS_STUCK_TIME_NS + `PRS_SYS_CLK_NS - 1) / `PRS_SYS_CLK_NS)
// reference rising edges the swap request must stay high
`define PRS_SWAP_MIN_EDGES 3
// time the user end holds the swap request high
`define PRS_SWAP_HOLD_NS 1200
`define PRS_SWAP_HOLD_CYC ((`PRS_SWAP_HOLD_NS + `PRS_SYS_CLK_NS - 1) / `PRS_SYS_CLK_NS)
// loop reset pulse after a switchover
`define PRS_LOOP_RST_NS 10
`define PRS_LOOP_RST_CYC ((`PRS_LOOP_RST_NS + `PRS_SYS_CLK_NS - 1) / `PRS_SYS_CLK_NS)
`define PRS_SEL_PRIMARY 1'h0
`define PRS_SEL_BACKUP 1'h1

`endif

// *** src/prs_pkg.sv ***
// types shared by both ends of the reference clock switchover
// assumes nothing beyond the compiler
`default_nettype none

package prs_pkg;

  typedef enum logic [1:0] {
    PRS_MODE_AUTO = 2'h0,
    PRS_MODE_MANUAL = 2'h1,
    PRS_MODE_OVERRIDE = 2'h2
  } prs_mode_t;

  typedef enum logic [2:0] {
    PRS_ST_RUN = 3'h1,
    PRS_ST_GATE = 3'h2,
    PRS_ST_SWAP = 3'h4
  } prs_state_t;

  typedef enum logic [2:0] {
    PRS_U_IDLE = 3'h1,
    PRS_U_HOLD = 3'h2,
    PRS_U_LOW = 3'h4
  } prs_ustate_t;

endpackage : prs_pkg

`default_nettype wire

// *** src/prs_if.sv ***
// link between the switchover selector and the user logic that drives it
// assumes both ends run on the same system clock
`default_nettype none

interface prs_if;
  logic swap_req;
  logic lost_primary;
  logic lost_backup;
  logic active_sel;

  modport dev (
    input swap_req,
    output lost_primary,
    output lost_backup,
    output active_sel
  );

  modport usr (
    output swap_req,
    input lost_primary,
    input lost_backup,
    input active_sel
  );
endinterface : prs_if

`default_nettype wire

// *** src/prs_user.sv ***
// user-side controller that issues swap requests to the switchover selector
// assumes the selector runs on the same SYS_CLK
`default_nettype none
`include "prs_regs.svh"

module prs_user (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic SWAP_GO,
  output logic SWAP_BUSY,
  output logic ACTIVE_SEL,
  output logic LOST_PRIMARY,
  output logic LOST_BACKUP,
  output logic LOOP_RESET,
  prs_if.usr link
);

  prs_pkg::prs_ustate_t ust_r;
  prs_pkg::prs_ustate_t ust_nxt;
  logic [5:0] hold_r;
  logic [5:0] hold_nxt;
  logic req_r;
  logic req_nxt;
  logic busy_r;
  logic busy_nxt;
  logic act_r;
  logic lost_p_r;
  logic lost_b_r;
  logic [1:0] rst_cnt_r;
  logic [1:0] rst_cnt_nxt;
  logic loop_rst_r;
  logic loop_rst_nxt;

  always_comb begin
    ust_nxt = ust_r;
    hold_nxt = hold_r;
    req_nxt = req_r;
    case (ust_r)
      prs_pkg::PRS_U_IDLE: begin
        if (SWAP_GO && !link.lost_primary && !link.lost_backup) begin
          ust_nxt = prs_pkg::PRS_U_HOLD;
          req_nxt = 1'h1;
          hold_nxt = 6'h00;
        end
      end
      prs_pkg::PRS_U_HOLD: begin
        if (hold_r == 6'(`PRS_SWAP_HOLD_CYC - 1)) begin
          ust_nxt = prs_pkg::PRS_U_LOW;
          req_nxt = 1'h0;
        end else begin
          hold_nxt = hold_r + 6'h01;
        end
      end
      prs_pkg::PRS_U_LOW: begin
        ust_nxt = prs_pkg::PRS_U_IDLE;
      end
      default: begin
        ust_nxt = prs_pkg::PRS_U_IDLE;
        req_nxt = 1'h0;
      end
    endcase
    busy_nxt = (ust_nxt != prs_pkg::PRS_U_IDLE);
    rst_cnt_nxt = 2'h0;
    if (link.active_sel != act_r) begin
      rst_cnt_nxt = 2'(`PRS_LOOP_RST_CYC);
    end else if (rst_cnt_r != 2'h0) begin
      rst_cnt_nxt = rst_cnt_r - 2'h1;
    end
    loop_rst_nxt = (rst_cnt_nxt != 2'h0);
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ust_r <= prs_pkg::PRS_U_IDLE;
      hold_r <= 6'h00;
      req_r <= 1'h0;
      busy_r <= 1'h0;
      act_r <= `PRS_SEL_PRIMARY;
      lost_p_r <= 1'h0;
      lost_b_r <= 1'h0;
      rst_cnt_r <= 2'h0;
      loop_rst_r <= 1'h0;
    end else begin
      ust_r <= ust_nxt;
      hold_r <= hold_nxt;
      req_r <= req_nxt;
      busy_r <= busy_nxt;
      act_r <= link.active_sel;
      lost_p_r <= link.lost_primary;
      lost_b_r <= link.lost_backup;
      rst_cnt_r <= rst_cnt_nxt;
      loop_rst_r <= loop_rst_nxt;
    end
  end

  assign link.swap_req = req_r;
  assign SWAP_BUSY = busy_r;
  assign ACTIVE_SEL = act_r;
  assign LOST_PRIMARY = lost_p_r;
  assign LOST_BACKUP = lost_b_r;
  assign LOOP_RESET = loop_rst_r;

endmodule : prs_user

`default_nettype wire

// *** test/prs_checker.sv ***
// checker: timing relations on the swap request link between the two ends
// assumes SYS_CLK samples every link signal and RESET is synchronous
`default_nettype none
`include "prs_regs.svh"

module prs_checker (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic swap_req,
  input wire logic lost_primary,
  input wire logic lost_backup,
  input wire logic active_sel
);
  logic [7:0] hi_cnt_r, hi_cnt_nxt;
  logic sel_d_r, sel_d_nxt, done_r, done_nxt;
  logic req_d_r, req_d_nxt;

  // counts high cycles of the request; marks a swap seen since the last request rise,
  // cleared while a lost flag explains an automatic move
  always_comb begin
    hi_cnt_nxt = swap_req ? hi_cnt_r + 8'h01 : 8'h00;
    sel_d_nxt = active_sel;
    req_d_nxt = swap_req;
    done_nxt = done_r || (active_sel != sel_d_r);
    if ((swap_req && !req_d_r) || lost_primary || lost_backup) begin
      done_nxt = 1'h0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      hi_cnt_r <= 8'h00;
      sel_d_r <= 1'h0;
      done_r <= 1'h0;
      req_d_r <= 1'h0;
    end else begin
      req_d_r <= req_d_nxt;
      hi_cnt_r <= hi_cnt_nxt;
      sel_d_r <= sel_d_nxt;
      done_r <= done_nxt;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking

  sequence s_req_rise;
    $rose(swap_req) && !lost_primary && !lost_backup;
  endsequence

  sequence s_sel_flip;
    ##[1:60] $changed(active_sel);
  endsequence

  a_rst_primary_sel: assert property (RESET |=> !active_sel)
    else $error("indicator not primary after reset");
  a_rst_links_low: assert property (RESET |=> !lost_primary && !lost_backup && !swap_req)
    else $error("link not idle after reset");
  a_req_hold_time: assert property (disable iff (RESET)
    $fell(swap_req) |-> hi_cnt_r == `PRS_SWAP_HOLD_CYC) else $error("request high time wrong");
  a_req_low_gap: assert property (disable iff (RESET) $fell(swap_req) |=> !swap_req)
    else $error("request raised again too soon");
  a_req_both_run: assert property (disable iff (RESET)
    $rose(swap_req) |-> !$past(lost_primary) && !$past(lost_backup))
    else $error("request raised with an input lost");
  a_swap_completes: assert property (disable iff (RESET) s_req_rise |-> s_sel_flip)
    else $error("swap request did not move the indicator");
  a_one_swap_each: assert property (disable iff (RESET)
    done_r |-> !$changed(active_sel)) else $error("second swap on one request");
  a_req_flags_low: assert property (disable iff (RESET)
    swap_req |-> !lost_primary && !lost_backup) else $error("lost flag during manual swap");
endmodule : prs_checker

`default_nettype wire

// *** test/tb.sv ***
// testbench: drives both reference pins, the mode and swap requests
// assumes the selector and the user end share SYS_CLK
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'h0;
  logic RESET = 1'h1;
  logic PRIMARY_REF_IN = 1'h0;
  logic BACKUP_REF_IN = 1'h0;
  logic SWAP_GO = 1'h0;
  logic run_p = 1'h1;
  logic run_b = 1'h1;
  logic gate_lo = 1'h0;
  logic rst_seen = 1'h0;
  logic ro_prev = 1'h0;
  prs_pkg::prs_mode_t MODE = prs_pkg::PRS_MODE_MANUAL;
  logic REF_OUT, REF_GATE_EN, REF_SEL, SWAP_BUSY, ACTIVE_SEL, LOST_PRIMARY, LOST_BACKUP;
  logic LOOP_RESET;
  int error_cnt = 0;
  int check_count = 0;
  int ph = 0;

  prs_if prs_if_i ();
  prs_switch prs_switch_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .PRIMARY_REF_IN(PRIMARY_REF_IN),
    .BACKUP_REF_IN(BACKUP_REF_IN), .MODE(MODE), .REF_OUT(REF_OUT), .REF_GATE_EN(REF_GATE_EN),
    .REF_SEL(REF_SEL), .link(prs_if_i.dev));
  prs_user prs_user_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .SWAP_GO(SWAP_GO),
    .SWAP_BUSY(SWAP_BUSY), .ACTIVE_SEL(ACTIVE_SEL), .LOST_PRIMARY(LOST_PRIMARY),
    .LOST_BACKUP(LOST_BACKUP), .LOOP_RESET(LOOP_RESET), .link(prs_if_i.usr));
  prs_checker prs_checker_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .swap_req(prs_if_i.swap_req),
    .lost_primary(prs_if_i.lost_primary), .lost_backup(prs_if_i.lost_backup),
    .active_sel(prs_if_i.active_sel));

  initial begin
    forever #20 SYS_CLK = ~SYS_CLK;
  end

  // both references run at eight system cycles a period, a quarter apart
  always @(posedge SYS_CLK) begin
    #1;
    ph = ph + 1;
    if (run_p && ph % 4 == 0) PRIMARY_REF_IN = ~PRIMARY_REF_IN;
    if (run_b && ph % 4 == 2) BACKUP_REF_IN = ~BACKUP_REF_IN;
    if (REF_GATE_EN === 1'h0) gate_lo = 1'h1;
    if (LOOP_RESET === 1'h1) rst_seen = 1'h1;
  end

  task automatic check(input logic seen, input logic exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : check

  task automatic wait_sel(input logic v);
    for (int i = 0; i < 100 && REF_SEL !== v; i++) begin
      @(posedge SYS_CLK);
      #2;
    end
  endtask : wait_sel

  task automatic swap(input logic v);
    gate_lo = 1'h0;
    @(posedge SYS_CLK);
    #1 SWAP_GO = 1'h1;
    @(posedge SYS_CLK);
    #1 SWAP_GO = 1'h0;
    check(SWAP_BUSY, 1'h1, "user end not busy after go");
    wait_sel(v);
    check(REF_SEL, v, "swap did not complete");
    check(REF_GATE_EN, 1'h1, "reference not reopened after swap");
    check(prs_if_i.active_sel, v, "indicator differs from select");
    check(gate_lo, 1'h1, "reference not gated during swap");
    for (int i = 0; i < 100 && SWAP_BUSY !== 1'h0; i++) @(posedge SYS_CLK);
    repeat (40) @(posedge SYS_CLK);
    #2;
    check(REF_SEL, v, "request fall moved select");
    check(SWAP_BUSY, 1'h0, "user end stuck busy");
    check(ACTIVE_SEL, v, "user end indicator copy differs");
    check(LOST_PRIMARY | LOST_BACKUP, 1'h0, "lost flag in manual swap");
  endtask : swap

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  initial begin
    #(20000 * 40);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge SYS_CLK);
    #1 RESET = 1'h0;
    repeat (20) @(posedge SYS_CLK);
    #2;
    check(REF_SEL, 1'h0, "primary not selected first");
    swap(1'h1);
    check(rst_seen, 1'h1, "no loop reset after swap");
    swap(1'h0);
    $display("test manual done");
    @(posedge SYS_CLK);
    #1 MODE = prs_pkg::PRS_MODE_OVERRIDE;
    swap(1'h1);
    $display("test override done");
    @(posedge SYS_CLK);
    #1 MODE = prs_pkg::PRS_MODE_AUTO;
    run_b = 1'h0;
    wait_sel(1'h0);
    check(REF_SEL, 1'h0, "no move off stalled input");
    check(LOST_BACKUP, 1'h1, "stalled input not flagged");
    run_b = 1'h1;
    repeat (40) @(posedge SYS_CLK);
    run_p = 1'h0;
    wait_sel(1'h1);
    check(REF_SEL, 1'h1, "no second automatic move");
    check(LOST_PRIMARY, 1'h1, "stalled primary not flagged");
    run_b = 1'h0;
    repeat (60) @(posedge SYS_CLK);
    #2;
    check(REF_SEL, 1'h1, "moved with both inputs idle");
    run_p = 1'h1;
    wait_sel(1'h0);
    check(REF_SEL, 1'h0, "no move once the other input came back");
    ro_prev = REF_OUT;
    repeat (4) @(posedge SYS_CLK);
    #2;
    check(REF_OUT, ~ro_prev, "reference output not following input");
    $display("test auto done");
    complete_run();
  end
endmodule : tb

`default_nettype wire
